/* tb/drh_dram_model.sv */
// behavioural model of the 4096 by 1 dynamic memory on the far side of the controller
`timescale 1ns/1ns
`default_nettype none
module drh_dram_model #(
	parameter int ACC_NS = 150,
	parameter realtime HOLD_NS = 2000000.0
) (
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic [5:0] row_address_lines,
	input wire logic wdata_pin,
	output logic rdata_pin,
	output int ref_count,
	output int seq_err
);
	// ----------------------------------------------------------------
	// array, row latch and output latch
	// ----------------------------------------------------------------
	logic mem [0:4095];
	realtime stamp [0:63];
	logic [5:0] row = 6'h00;
	logic [5:0] last_ref = 6'h00;
	logic sel = 1'b1;
	logic first = 1'b1;
	logic out_en = 1'b0;
	logic out_bit = 1'b0;
	initial begin
		ref_count = 0;
		seq_err = 0;
		for (int r = 0; r < 64; r++) stamp[r] = 0.0;
	end
	// released pin shows the inverse of the last bit, so a stale sample cannot pass
	assign rdata_pin = out_en ? out_bit : ~out_bit;
	always @(negedge ras_n) begin
		row = row_address_lines;
		sel = 1'b0;
		// a row left alone too long loses its contents
		if ($realtime - stamp[row] > HOLD_NS) begin
			for (int c = 0; c < 64; c++) mem[{c[5:0], row}] = ~mem[{c[5:0], row}];
		end
		stamp[row] = $realtime;
	end
	always @(negedge cas_n) begin
		out_en <= 1'b0;
		if (!ras_n && !cs_n) begin
			sel = 1'b1;
			if (!wr_n) begin
				mem[{row_address_lines, row}] = wdata_pin;
				out_bit <= #ACC_NS 1'b1;
			end else begin
				out_bit <= #ACC_NS mem[{row_address_lines, row}];
			end
			out_en <= #ACC_NS 1'b1;
		end
	end
	always @(posedge ras_n) begin
		if (!sel) begin
			ref_count++;
			if (!first && row != last_ref + 6'h01) seq_err++;
			last_ref = row;
			first = 1'b0;
		end
	end
endmodule
`default_nettype wire

/* tb/test_drh_ctrl.sv */
// self-checking testbench for the dynamic ram host controller
`timescale 1ns/1ns
`default_nettype none
module test_drh_ctrl;
	// ----------------------------------------------------------------
	// signals, design and memory model
	// ----------------------------------------------------------------
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic req_wdata = 1'b0;
	logic [11:0] req_addr = 12'h000;
	logic req_ready, rsp_valid, rsp_rdata, ras_n, cas_n, cs_n, wr_n, wdata_pin, rdata_pin;
	logic [5:0] row_address_lines;
	int ref_count, seq_err;
	int failures = 0;
	int checks_done = 0;
	logic [11:0] adr [6] = '{12'h000, 12'hFFF, 12'h03F, 12'hFC0, 12'h555, 12'hAAA};
	drh_ctrl uut (.core_clk(core_clk), .nrst(nrst), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.ras_n(ras_n), .cas_n(cas_n), .cs_n(cs_n), .wr_n(wr_n),
		.row_address_lines(row_address_lines), .wdata_pin(wdata_pin),
		.rdata_pin(rdata_pin));
	drh_dram_model dram (.ras_n(ras_n), .cas_n(cas_n), .cs_n(cs_n), .wr_n(wr_n),
		.row_address_lines(row_address_lines), .wdata_pin(wdata_pin),
		.rdata_pin(rdata_pin),
		.ref_count(ref_count), .seq_err(seq_err));
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task results;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// one request held until taken, then wait for completion; bounded so a hang is caught
	task access(input logic w, input logic [11:0] a, input logic d);
		int n;
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		n = 0;
		do begin @(posedge core_clk); n++; end while (req_ready !== 1'b1 && n < 100);
		req_valid <= 1'b0;
		check("taken", 16'(n < 100), 16'h0001);
		n = 0;
		do begin @(posedge core_clk); n++; end while (rsp_valid !== 1'b1 && n < 100);
		check("done", 16'(n < 100), 16'h0001);
	endtask
	// corner addresses split row and column; alternating bits expose a stale output latch
	task test_rw;
		for (int i = 0; i < 6; i++) access(1'b1, adr[i], i[0]);
		for (int i = 0; i < 6; i++) begin
			access(1'b0, adr[i], 1'b0);
			check("rdata", 16'(rsp_rdata), 16'(i[0]));
		end
		for (int i = 0; i < 6; i++) begin
			access(1'b1, adr[i], ~i[0]);
			access(1'b0, adr[i], 1'b0);
			check("rdata b2b", 16'(rsp_rdata), 16'(!i[0]));
		end
	endtask
	// one full refresh period: 64 rows in order, stored bits survive beyond 2 ms
	task test_refresh;
		int c0;
		access(1'b1, 12'h7C5, 1'b1);
		access(1'b1, 12'h13A, 1'b0);
		c0 = ref_count;
		repeat (40000) @(posedge core_clk);
		check("refresh rows", 16'(ref_count - c0), 16'h0040);
		check("refresh order", 16'(seq_err), 16'h0000);
		repeat (1000) @(posedge core_clk);
		access(1'b0, 12'h7C5, 1'b0);
		check("kept 1", 16'(rsp_rdata), 16'h0001);
		access(1'b0, 12'h13A, 1'b0);
		check("kept 0", 16'(rsp_rdata), 16'h0000);
	endtask
	initial begin
		repeat (60000) @(posedge core_clk);
		failures++;
		results;
	end
	initial begin
		repeat (8) @(posedge core_clk);
		// strobes idle and answers quiet while reset is held
		check("reset pins", 16'({ras_n, cas_n, cs_n, wr_n, req_ready, rsp_valid}), 16'h003C);
		nrst <= 1'b1;
		test_rw;
		test_refresh;
		results;
	end
endmodule
`default_nettype wire

/* verilog/drh_consts.svh */
// timing counts and widths for the dynamic ram host controller
`ifndef DRH_CONSTS_SVH
`define DRH_CONSTS_SVH
`define DRH_CLK_NS 50
`define DRH_ADDR_W 12
`define DRH_HALF_W 6
`define DRH_ROWS 64
`define DRH_REF_MS 2
// full array refresh in 2 ms, 64 rows, so one row every 31250 ns, rounded down
`define DRH_REF_ROW_CYC ((`DRH_REF_MS * 1000000) / `DRH_ROWS / `DRH_CLK_NS)
`define DRH_RAS_PRE_NS 125
`define DRH_RAS_PRE_CYC ((`DRH_RAS_PRE_NS + `DRH_CLK_NS - 1) / `DRH_CLK_NS)
`define DRH_RCD_NS 90
`define DRH_RCD_CYC ((`DRH_RCD_NS + `DRH_CLK_NS - 1) / `DRH_CLK_NS)
`define DRH_CAS_NS 200
`define DRH_CAS_CYC ((`DRH_CAS_NS + `DRH_CLK_NS - 1) / `DRH_CLK_NS)
`define DRH_RAS_NS 300
`define DRH_RAS_CYC ((`DRH_RAS_NS + `DRH_CLK_NS - 1) / `DRH_CLK_NS)
`endif

/* verilog/drh_ctrl.sv */
// host controller that drives a 4096 by 1 dynamic ram through its strobe pins
// ----------------------------------------------------------------
// Functional notes
// - refresh whole array every 2 ms
// - refresh walks all 64 rows sequentially
// - write: all strobes, select, write active
// - read: strobes, select active, write inactive
// - select inactive: refresh only, output floats
// ----------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "drh_consts.svh"
module drh_ctrl (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [`DRH_ADDR_W-1:0] req_addr,
	input wire logic req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic rsp_rdata,
	output logic ras_n,
	output logic cas_n,
	output logic cs_n,
	output logic wr_n,
	output logic [`DRH_HALF_W-1:0] row_address_lines,
	output logic wdata_pin,
	input wire logic rdata_pin
);
	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] REF_CYC = CNT_W'(`DRH_REF_ROW_CYC);
	localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'(`DRH_RCD_CYC);
	localparam logic [CNT_W-1:0] CAS_CYC = CNT_W'(`DRH_CAS_CYC);
	localparam logic [CNT_W-1:0] RAS_CYC = CNT_W'(`DRH_RAS_CYC);
	localparam logic [CNT_W-1:0] PRE_CYC = CNT_W'(`DRH_RAS_PRE_CYC);

	drh_pkg::drh_state_t state_reg;
	logic [CNT_W-1:0] tmr_reg;
	logic [CNT_W-1:0] ref_tmr_reg;
	logic ref_due_reg;
	logic [`DRH_HALF_W-1:0] ref_row_reg;
	logic is_ref_reg;
	logic is_wr_reg;
	logic [`DRH_ADDR_W-1:0] addr_reg;
	logic rd_sync;

	drh_sync u_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.d_raw(rdata_pin),
		.d_clean(rd_sync)
	);

	// ----------------------------------------------------------------
	// refresh pacing
	// ----------------------------------------------------------------
	// one row per interval, 64 rows fit inside 2 ms
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ref_tmr_reg <= '0;
			ref_due_reg <= 1'b0;
		end else begin
			if (ref_tmr_reg == REF_CYC - CNT_W'(1)) begin
				ref_tmr_reg <= '0;
				ref_due_reg <= 1'b1;
			end else begin
				ref_tmr_reg <= ref_tmr_reg + CNT_W'(1);
				// set wins over clear when both land together
				if (state_reg == drh_pkg::ST_IDLE && ref_due_reg) begin
					ref_due_reg <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// cycle sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= drh_pkg::ST_IDLE;
			tmr_reg <= '0;
			is_ref_reg <= 1'b0;
			is_wr_reg <= 1'b0;
			addr_reg <= '0;
			ref_row_reg <= '0;
		end else begin
			if (tmr_reg != '0) begin
				tmr_reg <= tmr_reg - CNT_W'(1);
			end
			unique case (state_reg)
				drh_pkg::ST_IDLE: begin
					// refresh goes before a waiting request; a cycle already running still delays it
					if (ref_due_reg) begin
						is_ref_reg <= 1'b1;
						addr_reg <= {{`DRH_HALF_W{1'b0}}, ref_row_reg};
						state_reg <= drh_pkg::ST_ROW;
					end else if (req_valid) begin
						is_ref_reg <= 1'b0;
						is_wr_reg <= req_write;
						addr_reg <= req_addr;
						state_reg <= drh_pkg::ST_ROW;
					end
				end
				drh_pkg::ST_ROW: begin
					tmr_reg <= RCD_CYC;
					state_reg <= drh_pkg::ST_RCD;
				end
				drh_pkg::ST_RCD: begin
					if (tmr_reg == '0) begin
						tmr_reg <= RAS_CYC > CAS_CYC ? RAS_CYC : CAS_CYC;
						state_reg <= drh_pkg::ST_CAS;
					end
				end
				drh_pkg::ST_CAS: begin
					if (tmr_reg == '0) begin
						tmr_reg <= PRE_CYC;
						state_reg <= drh_pkg::ST_PRE;
					end
				end
				drh_pkg::ST_PRE: begin
					if (tmr_reg == '0) begin
						state_reg <= drh_pkg::ST_DONE;
					end
				end
				drh_pkg::ST_DONE: begin
					if (is_ref_reg) begin
						ref_row_reg <= ref_row_reg + `DRH_HALF_W'(1);
					end
					state_reg <= drh_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ras_n <= 1'b1;
			cas_n <= 1'b1;
			cs_n <= 1'b1;
			wr_n <= 1'b1;
			row_address_lines <= '0;
			wdata_pin <= 1'b0;
		end else begin
			unique case (state_reg)
				drh_pkg::ST_IDLE: begin
					ras_n <= 1'b1;
					cas_n <= 1'b1;
					cs_n <= 1'b1;
					wr_n <= 1'b1;
					if (!ref_due_reg && req_valid) begin
						wdata_pin <= req_wdata;
						row_address_lines <= req_addr[`DRH_HALF_W-1:0];
					end else begin
						row_address_lines <= ref_row_reg;
					end
				end
				drh_pkg::ST_ROW: begin
					ras_n <= 1'b0;
				end
				drh_pkg::ST_RCD: begin
					if (tmr_reg == '0) begin
						// column half presented a cycle before its strobe falls
						row_address_lines <= addr_reg[`DRH_ADDR_W-1:`DRH_HALF_W];
						cs_n <= is_ref_reg;
						wr_n <= is_ref_reg | ~is_wr_reg;
					end
				end
				drh_pkg::ST_CAS: begin
					// refresh-only cycles still pulse the column strobe with select off
					cas_n <= 1'b0;
					if (tmr_reg == '0) begin
						ras_n <= 1'b1;
						cas_n <= 1'b1;
						cs_n <= 1'b1;
						wr_n <= 1'b1;
					end
				end
				drh_pkg::ST_PRE: begin
					ras_n <= 1'b1;
				end
				drh_pkg::ST_DONE: begin
					ras_n <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// request answer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= 1'b0;
		end else begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			if (state_reg == drh_pkg::ST_IDLE && !ref_due_reg && req_valid) begin
				req_ready <= 1'b1;
			end
			// latched device output still holds after the strobes rise
			if (state_reg == drh_pkg::ST_DONE && !is_ref_reg) begin
				rsp_valid <= 1'b1;
				if (!is_wr_reg) begin
					rsp_rdata <= rd_sync;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	refresh_sel_off_a: assert property (
		state_reg == drh_pkg::ST_CAS && is_ref_reg |-> cs_n)
		else $error("select active during refresh");
	write_line_a: assert property (
		!cas_n && !is_ref_reg |-> wr_n == !is_wr_reg)
		else $error("write line wrong in strobe cycle");
	read_select_a: assert property (
		!cas_n && !is_ref_reg && !is_wr_reg |-> !cs_n && wr_n && !ras_n)
		else $error("read cycle pins wrong");
	row_before_col_a: assert property (
		$fell(ras_n) |-> cas_n [*2])
		else $error("column strobe too early");
	cas_under_ras_a: assert property (
		$fell(cas_n) |-> !ras_n)
		else $error("column strobe without row strobe");
	ref_row_step_a: assert property (
		state_reg == drh_pkg::ST_DONE && is_ref_reg
			|=> ref_row_reg == $past(ref_row_reg) + 6'h01)
		else $error("refresh row did not advance");
	ref_served_a: assert property (
		$rose(ref_due_reg) |-> ##[1:40] (state_reg == drh_pkg::ST_ROW && is_ref_reg))
		else $error("refresh not started in time");
	ready_answer_a: assert property (
		req_ready && !is_wr_reg |-> ##[5:30] rsp_valid)
		else $error("read answer missing");
	idle_strobes_a: assert property (
		state_reg == drh_pkg::ST_IDLE && $past(state_reg) == drh_pkg::ST_IDLE
			|-> ras_n && cas_n)
		else $error("strobes active in standby");
	addr_range_a: assert property (
		req_ready |-> addr_reg == $past(req_addr)
			&& row_address_lines == addr_reg[`DRH_HALF_W-1:0])
		else $error("address not captured");

	cov_read_c: cover property (rsp_valid && !is_wr_reg);
	cov_write_c: cover property (rsp_valid && is_wr_reg);
	cov_refresh_c: cover property (state_reg == drh_pkg::ST_DONE && is_ref_reg);
	cov_wrap_c: cover property (ref_row_reg == 6'h3F ##1 state_reg == drh_pkg::ST_DONE);
endmodule
`default_nettype wire

/* verilog/drh_pkg.sv */
// types for the dynamic ram host controller
`default_nettype none
package drh_pkg;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ROW = 6'h02,
		ST_RCD = 6'h04,
		ST_CAS = 6'h08,
		ST_PRE = 6'h10,
		ST_DONE = 6'h20
	} drh_state_t;
endpackage
`default_nettype wire

/* verilog/drh_sync.sv */
// three-stage synchroniser for the data pin coming back from the memory
`timescale 1ns/1ns
`default_nettype none
module drh_sync (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic d_raw,
	output logic d_clean
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			d_clean <= 1'b0;
		end else begin
			s1_reg <= d_raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			// a change only counts once two later stages agree
			if (s2_reg == s3_reg) begin
				d_clean <= s3_reg;
			end
		end
	end
endmodule
`default_nettype wire
